// *** inc/alsw_defs.vh ***
/*
 * constants for the auxiliary switch and link settings register bank:
 * register indexes, field positions, reset values and the termination
 * pulse timing. assumes a 250 MHz mclk and a byte-wide register port
 * fed by the serial or parallel control front end.
 */
`ifndef ALSW_DEFS_VH
`define ALSW_DEFS_VH

// register indexes on the byte port
`define ALSW_IDX_AUX_MODES    3'h0
`define ALSW_IDX_RX_SETTINGS  3'h1
`define ALSW_IDX_PULSE_AB     3'h2
`define ALSW_IDX_PULSE_CD     3'h3
`define ALSW_IDX_EQ_AB        3'h4
`define ALSW_IDX_EQ_CD        3'h5
`define ALSW_IDX_TX_SETTINGS  3'h6

// aux device modes fields
`define ALSW_AUX_EN_BIT       6
`define ALSW_AUX_MODE_HI      5
`define ALSW_AUX_MODE_LO      4
`define ALSW_AUX_SEL_HI       3
`define ALSW_AUX_SEL_LO       0

// aux mode encodings
`define ALSW_MODE_QUAD        2'h0
`define ALSW_MODE_DUAL        2'h1
`define ALSW_MODE_SINGLE      2'h2
`define ALSW_MODE_ILLEGAL     2'h3

// receiver and transmitter fields
`define ALSW_TERM_EN_BIT      0
`define ALSW_PREEMPH_HI       3
`define ALSW_PREEMPH_LO       2

// reset values
`define ALSW_RST_AUX_MODES    8'h00
`define ALSW_RST_RX_SETTINGS  8'h00
`define ALSW_RST_PULSE        8'h00
`define ALSW_RST_EQ           8'h00
`define ALSW_RST_TX_SETTINGS  8'h00

// timing
`define ALSW_MCLK_KHZ         250000
`define ALSW_TERM_PULSE_MS    100
`define ALSW_TERM_PULSE_CYC   (`ALSW_TERM_PULSE_MS * `ALSW_MCLK_KHZ)
`define ALSW_TIMER_W          25

`endif

// *** design/alsw_pulse_timer.v ***
/*
 * one-shot interval timer for the termination disconnect pulse.
 * assumes start is a one-cycle pulse on mclk; a start while busy
 * restarts the full interval.
 */
`default_nettype none
`include "alsw_defs.vh"

module alsw_pulse_timer #(
   parameter [`ALSW_TIMER_W-1:0] CYCLES = `ALSW_TERM_PULSE_CYC
) (
   // clock and reset
   input  wire                      mclk,
   input  wire                      arst_n,
   // control
   input  wire                      start,
   output reg                       busy_q
);

   reg [`ALSW_TIMER_W-1:0] count_q;

   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         count_q <= {`ALSW_TIMER_W{1'b0}};
         busy_q  <= 1'b0;
      end else if (start) begin
         count_q <= CYCLES - 1'b1;
         busy_q  <= 1'b1;
      end else if (count_q != {`ALSW_TIMER_W{1'b0}}) begin
         count_q <= count_q - 1'b1;
      end else begin
         busy_q  <= 1'b0;
      end
   end

endmodule // alsw_pulse_timer
`default_nettype wire

// *** design/alsw_settings.v ***
/*
 * auxiliary switch and link settings register bank. holds the aux
 * routing, input termination, equalization and pre-emphasis settings
 * and decodes them into per-line controls for the analog fabric.
 * assumes a byte-wide register port driven by the serial or parallel
 * control front end, all inputs synchronous to mclk.
 */
`default_nettype none
`include "alsw_defs.vh"

module alsw_settings #(
   parameter [`ALSW_TIMER_W-1:0] TERM_PULSE_CYCLES = `ALSW_TERM_PULSE_CYC
) (
   // clock and reset
   input  wire        mclk,
   input  wire        arst_n,
   // register port
   input  wire [2:0]  reg_addr,
   input  wire        reg_wr,
   input  wire        reg_rd,
   input  wire [7:0]  reg_wdata,
   output reg  [7:0]  reg_rdata_q,
   // high speed source select from the main switch
   input  wire [3:0]  hs_source_select,
   // aux fabric controls: bit o*16+c joins input c to output line o
   output reg  [63:0] aux_conn_q,
   // input channel controls, channel order A0..A3 B0..B3 C0..C3 D0..D3
   output reg  [15:0] term_on_q,
   output reg  [15:0] eq_high_q,
   // output driver control
   output reg  [1:0]  preemph_q
);

   // register storage
   reg [7:0]  aux_modes_q;
   reg [7:0]  rx_settings_q;
   reg [15:0] pulse_sel_q;
   reg [15:0] eq_sel_q;
   reg [7:0]  tx_settings_q;
   reg [3:0]  hs_src_q;
   reg        src_seen_q;
   reg [15:0] pulse_mask_q;
   reg [63:0] aux_conn_d;

   wire       aux_enable_w;
   wire [1:0] aux_mode_w;
   wire [3:0] aux_sel_w;
   wire       term_enable_w;
   wire       src_change_w;
   wire       pulse_busy_w;
   wire [15:0] pulse_by_ch_w;
   wire [15:0] eq_by_ch_w;

   assign aux_enable_w  = aux_modes_q[`ALSW_AUX_EN_BIT];
   assign aux_mode_w    = aux_modes_q[`ALSW_AUX_MODE_HI:`ALSW_AUX_MODE_LO];
   assign aux_sel_w     = aux_modes_q[`ALSW_AUX_SEL_HI:`ALSW_AUX_SEL_LO];
   assign term_enable_w = rx_settings_q[`ALSW_TERM_EN_BIT];

   // register writes
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         aux_modes_q   <= `ALSW_RST_AUX_MODES;
         rx_settings_q <= `ALSW_RST_RX_SETTINGS;
         pulse_sel_q   <= {`ALSW_RST_PULSE, `ALSW_RST_PULSE};
         eq_sel_q      <= {`ALSW_RST_EQ, `ALSW_RST_EQ};
         tx_settings_q <= `ALSW_RST_TX_SETTINGS;
      end else if (reg_wr) begin
         case (reg_addr)
            `ALSW_IDX_AUX_MODES: begin
               aux_modes_q[7:6] <= reg_wdata[7:6];
               aux_modes_q[3:0] <= reg_wdata[3:0];
               if (reg_wdata[`ALSW_AUX_MODE_HI:`ALSW_AUX_MODE_LO] != `ALSW_MODE_ILLEGAL) begin
                  aux_modes_q[5:4] <= reg_wdata[5:4];
               end
            end
            `ALSW_IDX_RX_SETTINGS: rx_settings_q <= reg_wdata;
            `ALSW_IDX_PULSE_AB:    pulse_sel_q[7:0] <= reg_wdata;
            `ALSW_IDX_PULSE_CD:    pulse_sel_q[15:8] <= reg_wdata;
            `ALSW_IDX_EQ_AB:       eq_sel_q[7:0] <= reg_wdata;
            `ALSW_IDX_EQ_CD:       eq_sel_q[15:8] <= reg_wdata;
            `ALSW_IDX_TX_SETTINGS: tx_settings_q <= reg_wdata;
            default: ;
         endcase
      end
   end

   // registered read, unmapped index reads zero
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `ALSW_IDX_AUX_MODES:   reg_rdata_q <= aux_modes_q;
            `ALSW_IDX_RX_SETTINGS: reg_rdata_q <= rx_settings_q;
            `ALSW_IDX_PULSE_AB:    reg_rdata_q <= pulse_sel_q[7:0];
            `ALSW_IDX_PULSE_CD:    reg_rdata_q <= pulse_sel_q[15:8];
            `ALSW_IDX_EQ_AB:       reg_rdata_q <= eq_sel_q[7:0];
            `ALSW_IDX_EQ_CD:       reg_rdata_q <= eq_sel_q[15:8];
            `ALSW_IDX_TX_SETTINGS: reg_rdata_q <= tx_settings_q;
            default:               reg_rdata_q <= 8'h00;
         endcase
      end
   end

   // aux routing decode, one output line and input channel per entry
   always @* begin
      aux_conn_d = 64'h0;
      if (aux_enable_w) begin
         case (aux_mode_w)
            `ALSW_MODE_QUAD: begin
               aux_conn_d[0*16 + {aux_sel_w[1:0], 2'h0}] = 1'b1;
               aux_conn_d[1*16 + {aux_sel_w[1:0], 2'h1}] = 1'b1;
               aux_conn_d[2*16 + {aux_sel_w[1:0], 2'h2}] = 1'b1;
               aux_conn_d[3*16 + {aux_sel_w[1:0], 2'h3}] = 1'b1;
            end
            `ALSW_MODE_DUAL: begin
               aux_conn_d[0*16 + {1'b0, aux_sel_w[2], aux_sel_w[1:0]}] = 1'b1;
               aux_conn_d[2*16 + {1'b1, aux_sel_w[2], aux_sel_w[1:0]}] = 1'b1;
            end
            `ALSW_MODE_SINGLE: begin
               aux_conn_d[0*16 + aux_sel_w] = 1'b1;
            end
            default: aux_conn_d = 64'h0;
         endcase
      end
   end

   // source change detect, first value after reset is not a change
   assign src_change_w = src_seen_q && (hs_source_select != hs_src_q);

   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         hs_src_q   <= 4'h0;
         src_seen_q <= 1'b0;
      end else begin
         hs_src_q   <= hs_source_select;
         src_seen_q <= 1'b1;
      end
   end

   // one shared interval for all pulsed channels
   alsw_pulse_timer #(
      .CYCLES (TERM_PULSE_CYCLES)
   ) u_timer (
      .mclk   (mclk),
      .arst_n (arst_n),
      .start  (src_change_w && term_enable_w),
      .busy_q (pulse_busy_w)
   );

   // channel bit ordering, register bit to channel
   genvar g;
   generate
      for (g = 0; g < 16; g = g + 1) begin : g_chan
         localparam integer BP = (g < 4) ? g + 4 : (g < 8) ? g - 4 : (g < 12) ? 19 - g : 27 - g;
         assign pulse_by_ch_w[g] = pulse_sel_q[BP];
         assign eq_by_ch_w[g]    = eq_sel_q[BP];
      end
   endgenerate

   // pulsed channel mask, captured on the change; a later change adds channels
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pulse_mask_q <= 16'h0000;
      end else if (src_change_w && term_enable_w) begin
         pulse_mask_q <= (pulse_busy_w ? pulse_mask_q : 16'h0000) | pulse_by_ch_w;
      end else if (!pulse_busy_w) begin
         pulse_mask_q <= 16'h0000;
      end
   end

   // output controls, all registered for glitch-free analog switching
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         aux_conn_q <= 64'h0;
         term_on_q  <= 16'h0000;
         eq_high_q  <= 16'h0000;
         preemph_q  <= 2'h0;
      end else begin
         aux_conn_q <= aux_conn_d;
         if (!term_enable_w) begin
            term_on_q <= 16'h0000;
         end else if (src_change_w) begin
            // open on the change cycle itself so the gap is the full interval
            term_on_q <= ~(pulse_by_ch_w | (pulse_busy_w ? pulse_mask_q : 16'h0000));
         end else begin
            term_on_q <= ~(pulse_busy_w ? pulse_mask_q : 16'h0000);
         end
         eq_high_q <= eq_by_ch_w;
         preemph_q <= tx_settings_q[`ALSW_PREEMPH_HI:`ALSW_PREEMPH_LO];
      end
   end

endmodule // alsw_settings
`default_nettype wire

// *** tb/alsw_settings_monitor.sv ***
/* port checker for the settings bank.
   assumes binding onto every alsw_settings, one mclk domain. */
`default_nettype none
module alsw_settings_monitor (
   // clock and reset
   input wire logic        mclk,
   input wire logic        arst_n,
   // register port
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [2:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic [7:0]  reg_rdata_q,
   // fabric side
   input wire logic [3:0]  hs_source_select,
   input wire logic [63:0] aux_conn_q,
   input wire logic [15:0] term_on_q,
   input wire logic [15:0] eq_high_q,
   input wire logic [1:0]  preemph_q
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   logic [3:0] src_q;
   logic [7:0] wd_q, wd_qq;
   // one-hot write strobe per index, fold of the four aux lines
   wire [7:0]  w   = {8{reg_wr}} & (8'h01 << reg_addr);
   wire [15:0] fld = aux_conn_q[15:0] | aux_conn_q[31:16] | aux_conn_q[47:32] | aux_conn_q[63:48];
   wire        chg = hs_source_select != src_q;
   // write data two edges back lines up with the decoded outputs
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) {src_q, wd_q, wd_qq} <= 20'h0;
      else {src_q, wd_q, wd_qq} <= {hs_source_select, reg_wdata, wd_q};
   end
   a_quad_route: assert property (w[0] && reg_wdata[6:4] == 3'h4 ##1 !w[0]
      |=> aux_conn_q == (64'h0008_0004_0002_0001 << {wd_qq[1:0], 2'h0})) else $error("quad route wrong");
   a_dual_route: assert property (w[0] && reg_wdata[6:4] == 3'h5 ##1 !w[0]
      |=> aux_conn_q == (64'h0000_0100_0000_0001 << wd_qq[2:0])) else $error("dual route wrong");
   a_single_route: assert property (w[0] && reg_wdata[6:4] == 3'h6 ##1 !w[0]
      |=> fld == (16'h1 << wd_qq[3:0]) && $countones(aux_conn_q) == 1) else $error("single route wrong");
   a_aux_off: assert property (w[0] && !reg_wdata[6] ##1 !w[0]
      |=> aux_conn_q == 64'h0) else $error("aux joined while off");
   a_term_off: assert property (w[1] && !reg_wdata[0] ##1 !w[1]
      |=> term_on_q == 16'h0) else $error("termination on while off");
   a_eq_cd_map: assert property (w[5] ##1 !w[5]
      |=> {eq_high_q[12], eq_high_q[13], eq_high_q[14], eq_high_q[15], eq_high_q[8], eq_high_q[9],
      eq_high_q[10], eq_high_q[11]} == wd_qq) else $error("eq cd order wrong");
   a_preemph_set: assert property (w[6] ##1 !w[6]
      |=> preemph_q == wd_qq[3:2]) else $error("pre-emphasis wrong");
   a_term_fall: assert property (|(~term_on_q & $past(term_on_q))
      |-> $past(chg) || $past(w[1], 2)) else $error("termination dropped without cause");
endmodule // alsw_settings_monitor
bind alsw_settings alsw_settings_monitor u_mon (.mclk, .arst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
   .reg_rdata_q, .hs_source_select, .aux_conn_q, .term_on_q, .eq_high_q, .preemph_q);
`default_nettype wire

// *** tb/alsw_host.sv ***
/* host model driving the register port and the source select.
   assumes one shared mclk; idle lines show inverted last values. */
`default_nettype none
module alsw_host (
   // clock and read data
   input wire logic        mclk,
   input wire logic [7:0]  reg_rdata_q,
   // register port and source select
   output logic [2:0]      reg_addr,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic [7:0]      reg_wdata,
   output logic [3:0]      hs_source_select
);
   timeunit 1ns;
   timeprecision 1ps;
   // everything idle at time zero
   initial {reg_addr, reg_wr, reg_rd, reg_wdata, hs_source_select} = 17'h0;
   // one strobe edge per write; released bus carries inverted data
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge mclk);
      {reg_addr, reg_wdata, reg_wr} <= {~a, ~d, 1'b0};
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge mclk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge mclk);
      {reg_addr, reg_rd} <= {~a, 1'b0};
      @(negedge mclk);
      d = reg_rdata_q;
   endtask
   task automatic src(input logic [3:0] s);
      @(posedge mclk);
      hs_source_select <= s;
   endtask
endmodule // alsw_host
`default_nettype wire

// *** tb/test_alsw_settings.sv ***
/* self-checking bench for the settings bank with the host model.
   assumes a shortened pulse count so the run stays short. */
`default_nettype none
`include "alsw_defs.vh"
module test_alsw_settings;
   timeunit 1ns;
   timeprecision 1ps;
   localparam [`ALSW_TIMER_W-1:0] CYC = 20;
   logic        mclk, arst_n, reg_wr, reg_rd;
   logic [2:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata_q, v;
   logic [3:0]  hs_source_select;
   logic [63:0] aux_conn_q;
   logic [15:0] term_on_q, eq_high_q;
   logic [1:0]  preemph_q;
   int          errors, n_checks, cnt, i, tmo;
   // the four aux lines folded onto one, single mode only drives line 0
   wire [63:0]  aux_fold = {48'h0, aux_conn_q[15:0] | aux_conn_q[31:16] | aux_conn_q[47:32] | aux_conn_q[63:48]};
   // mode byte written, byte read back, route expected (single mode folded)
   logic [79:0] rows [11] = '{{8'h40, 8'h40, 64'h0008_0004_0002_0001}, {8'h45, 8'h45, 64'h0080_0040_0020_0010},
      {8'h4f, 8'h4f, 64'h8000_4000_2000_1000}, {8'h0f, 8'h0f, 64'h0}, {8'h50, 8'h50, 64'h0000_0100_0000_0001},
      {8'h56, 8'h56, 64'h0000_4000_0000_0040}, {8'h5f, 8'h5f, 64'h0000_8000_0000_0080},
      {8'h73, 8'h53, 64'h0000_0800_0000_0008}, {8'h60, 8'h60, 64'h1}, {8'h69, 8'h69, 64'h200},
      {8'h6f, 8'h6f, 64'h8000}};
   alsw_host host (.mclk, .reg_rdata_q, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .hs_source_select);
   alsw_settings #(.TERM_PULSE_CYCLES(CYC)) dut (.mclk, .arst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
      .reg_rdata_q, .hs_source_select, .aux_conn_q, .term_on_q, .eq_high_q, .preemph_q);
   task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
      n_checks++;
      if (s !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wait_term(input logic [15:0] t);
      cnt = 0;
      while (term_on_q !== t && cnt < 60) begin
         @(negedge mclk);
         cnt++;
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // free-running clock, 4 ns period
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // hang guard well above the expected run length
   always @(posedge mclk) begin
      tmo++;
      if (tmo == 3000) begin
         errors++;
         close_out;
      end
   end
   initial begin
      arst_n = 1'b0;
      repeat (4) @(posedge mclk);
      arst_n <= 1'b1;
      chk("term after reset", term_on_q, 64'h0);
      for (i = 0; i < 11; i++) begin
         host.wr(3'h0, rows[i][79:72]);
         host.rd(3'h0, v);
         chk("mode byte", v, rows[i][71:64]);
         chk("aux route", rows[i][69:68] == 2'h2 ? aux_fold : aux_conn_q, rows[i][63:0]);
      end
      $display("aux routing done");
      host.wr(3'h4, 8'h1e);
      host.wr(3'h5, 8'h81);
      host.rd(3'h4, v);
      chk("eq ab byte", v, 64'h1e);
      chk("eq levels", eq_high_q, 64'h18e1);
      for (i = 0; i < 4; i++) begin
         host.wr(3'h6, {4'h0, i[1:0], 2'h1});
         host.rd(3'h6, v);
         chk("tx byte", v, {4'h0, i[1:0], 2'h1});
         chk("pre-emphasis", preemph_q, i[1:0]);
      end
      $display("levels done");
      host.wr(3'h2, 8'h81);
      host.wr(3'h3, 8'h10);
      host.wr(3'h1, 8'h01);
      host.rd(3'h1, v);
      chk("term enable byte", v, 64'h01);
      chk("term on", term_on_q, 64'hffff);
      host.src(4'h3);
      wait_term(16'h7fe7);
      chk("term pulse mask", term_on_q, 64'h7fe7);
      wait_term(16'hffff);
      chk("pulse length", cnt >= CYC - 2 && cnt <= CYC + 3, 64'h1);
      host.wr(3'h1, 8'h00);
      host.src(4'h5);
      repeat (3) @(negedge mclk);
      chk("term off pulse", term_on_q, 64'h0);
      host.wr(3'h7, 8'hff);
      host.rd(3'h7, v);
      chk("unmapped read", v, 64'h0);
      $display("termination done");
      @(posedge mclk);
      arst_n <= 1'b0;
      @(negedge mclk);
      chk("aux in reset", aux_conn_q, 64'h0);
      chk("lines in reset", {reg_rdata_q, term_on_q, eq_high_q, preemph_q}, 64'h0);
      repeat (4) @(posedge mclk);
      arst_n <= 1'b1;
      host.rd(3'h2, v);
      chk("pulse reset value", v, 64'h0);
      $display("reset done");
      close_out;
   end
endmodule // test_alsw_settings
`default_nettype wire
